// ### motor_regs_pkg.sv
package motor_regs_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, 8-bit data)
  // ---------------------------------------------------------------
  localparam logic [2:0] OFF_CONTROL_B = 3'h0;
  localparam logic [2:0] OFF_CONTROL_C = 3'h1;
  localparam logic [2:0] OFF_PHASE_STATE = 3'h2;
  localparam logic [2:0] OFF_CURRENT_FEEDBACK = 3'h3;
  // page 0: mode control, page 1: d event filter
  localparam logic [2:0] OFF_PAGED = 3'h4;

  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [7:0] RST_CONTROL_C = 8'h00;
  localparam logic [7:0] RST_PHASE_STATE = 8'h00;
  localparam logic [7:0] RST_CURRENT_FEEDBACK = 8'h00;
  localparam logic [7:0] RST_D_EVENT_FILTER = 8'h0f;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CC_FLAG_BIT = 7;
  localparam int CC_DIR_HZ_BIT = 6;
  localparam int CC_SZ_BIT = 5;
  localparam int CC_SC_BIT = 4;
  localparam int CC_FAST_ZERO_SAMPLING_BIT = 3;
  localparam int CFR_PAGE_BIT = 7;
  localparam int CFR_RST_BIT = 6;
  localparam logic [7:0] CB_PRELOAD_MASK = 8'h74;
  localparam logic [2:0] VR_EXTERNAL = 3'h7;
  localparam logic [1:0] IS_ENCODER = 2'h3;
  localparam logic [1:0] TES_POSITION = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_STEP_NS = 500;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D_WIN_FINE_NS = 5000;
  localparam int D_WIN_FINE_CYC = (D_WIN_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D_WIN_COARSE_NS = 20000;
  localparam int D_WIN_COARSE_CYC = (D_WIN_COARSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D_WIN_BREAK_NS = 60000;
  localparam int D_WIN_BREAK_CYC = (D_WIN_BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CUR_DIV_LAST = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] input_sel;
    logic [5:0] channel_on;
  } phase_state_t;

  typedef struct packed {
    logic [2:0] spare;
    logic direct_access;
    logic position_sensor_mode;
    logic autoswitched_mode;
    logic [1:0] speed_sensor_type_select;
  } mode_ctrl_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CONTROL_B,
    SEL_CONTROL_C,
    SEL_PHASE,
    SEL_CFR,
    SEL_MODE,
    SEL_DFR
  } reg_sel_t;

endpackage

// ### motor_ctrl_phase_filter_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - direct access: low mode bit picks PWM side
// - sensor type 00: bit7 is overflow flag
// - other sensor types: bit7 is tacho error
// - position/sensorless: bit6 selects hardware zero crossing
// - speed sensor: bit6 reports encoder A lead
// - bit5 requests simulated zero crossing
// - autoswitched: bit4 picks simulated commutation
// - sensorless Z sampling: PWM end or fast
// - fast sampling forces minimum off time zero
// - threshold code 111 selects external reference
// - input select maps A/B/C, 11 encoder
// - channel bits apply at C or immediately
// - page bit routes accesses to page 0/1
// - soft reset bit resets peripheral registers
// - over-current after field+1 quarter-rate samples
// - blank current comparator after PWM turn-on
// - D event after field+1 consecutive samples, sensorless; after 1 sample in position mode
// - D detection blanked after C event, sensorless
module motor_ctrl_phase_filter_regs
  import motor_regs_pkg::*;
#(
  parameter int D_WIN_FINE = D_WIN_FINE_CYC,
  parameter int D_WIN_COARSE = D_WIN_COARSE_CYC,
  parameter int D_WIN_BREAK = D_WIN_BREAK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // motor events and sensors
  input wire logic motor_timer_overflow_i,
  input wire logic tacho_error_i,
  input wire logic rotor_input_a_i,
  input wire logic rotor_input_b_i,
  input wire logic c_event_i,
  input wire logic pwm_off_end_i,
  input wire logic fast_sample_clock_i,
  input wire logic pwm_turn_on_i,
  input wire logic current_above_i,
  input wire logic d_detect_i,
  input wire logic [3:0] minimum_off_time_i,
  // control outputs
  output logic hardware_zero_cross_select_o,
  output logic simulated_zero_cross_o,
  output logic simulated_commutation_o,
  output logic z_sample_strobe_o,
  output logic [3:0] effective_off_time_o,
  output logic [2:0] threshold_level_select_o,
  output logic external_threshold_pin_sel_o,
  output logic [2:0] comparator_channel_o,
  output logic encoder_mode_o,
  output logic [5:0] channel_on_bits_o,
  output logic [7:0] control_b_active_o,
  output logic pwm_low_side_o,
  output logic c_event_o,
  output logic over_current_o,
  output logic d_event_o
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [2:0] addr, input logic page);
    unique case (addr)
      OFF_CONTROL_B: decode = SEL_CONTROL_B;
      OFF_CONTROL_C: decode = SEL_CONTROL_C;
      OFF_PHASE_STATE: decode = SEL_PHASE;
      OFF_CURRENT_FEEDBACK: decode = SEL_CFR;
      OFF_PAGED: decode = page ? SEL_DFR : SEL_MODE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  logic ack_q;
  logic req;
  logic wr_take;
  logic rd_first;
  logic sw_rst;
  reg_sel_t sel;
  logic page_q;
  logic flag_q, hz_q, sz_q, sc_q, fast_zero_sampling_q;
  logic [2:0] vr_q;
  logic [7:0] control_b_q, cb_act_q;
  phase_state_t phase_q, phase_act_q;
  mode_ctrl_t mode_q;
  logic [2:0] cff_q, cfw_q;
  logic [7:0] dfr_q;
  logic enc_dir_q, a_q, b_q;
  logic dac_c_q;
  logic [7:0] rd_val;
  logic speed_mode;

  // one wait state: the edge after the request is the answer edge
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take = avs_write_i & ack_q;
  assign rd_first = avs_read_i & ~ack_q;
  assign sel = decode(avs_address_i, page_q);
  assign speed_mode = (mode_q.speed_sensor_type_select != TES_POSITION);
  assign sw_rst = wr_take & (sel == SEL_CFR) & avs_writedata_i[CFR_RST_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (sel)
      SEL_CONTROL_B: rd_val = {1'b0, control_b_q[6:0]};
      // bit6 read-only direction in speed mode
      SEL_CONTROL_C: rd_val = {flag_q, speed_mode ? enc_dir_q : hz_q, sz_q, sc_q, fast_zero_sampling_q, vr_q};
      SEL_PHASE: rd_val = phase_q;
      SEL_CFR: rd_val = {page_q, 1'b0, cff_q, cfw_q};
      SEL_MODE: rd_val = mode_q;
      SEL_DFR: rd_val = dfr_q;
      SEL_NONE: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 8'h00;
    end else if (rd_first) begin
      avs_readdata_o <= rd_val;
    end
  end

  // ---------------------------------------------------------------
  // control c
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= RST_CONTROL_C[CC_FLAG_BIT];
    end else if (sw_rst) begin
      flag_q <= RST_CONTROL_C[CC_FLAG_BIT];
    // overflow sets flag, set beats clear
    end else if (!speed_mode && motor_timer_overflow_i) begin
      flag_q <= 1'b1;
    end else if (speed_mode && tacho_error_i) begin
      flag_q <= 1'b1;
    end else if (wr_take && sel == SEL_CONTROL_C && !avs_writedata_i[CC_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hz_q <= RST_CONTROL_C[CC_DIR_HZ_BIT];
      sz_q <= RST_CONTROL_C[CC_SZ_BIT];
      sc_q <= RST_CONTROL_C[CC_SC_BIT];
      fast_zero_sampling_q <= RST_CONTROL_C[CC_FAST_ZERO_SAMPLING_BIT];
      vr_q <= RST_CONTROL_C[2:0];
    end else if (sw_rst) begin
      hz_q <= RST_CONTROL_C[CC_DIR_HZ_BIT];
      sz_q <= RST_CONTROL_C[CC_SZ_BIT];
      sc_q <= RST_CONTROL_C[CC_SC_BIT];
      fast_zero_sampling_q <= RST_CONTROL_C[CC_FAST_ZERO_SAMPLING_BIT];
      vr_q <= RST_CONTROL_C[2:0];
    end else if (wr_take && sel == SEL_CONTROL_C) begin
      // hz writable only outside speed mode
      if (!speed_mode) begin
        hz_q <= avs_writedata_i[CC_DIR_HZ_BIT];
      end
      sz_q <= avs_writedata_i[CC_SZ_BIT];
      sc_q <= avs_writedata_i[CC_SC_BIT];
      fast_zero_sampling_q <= avs_writedata_i[CC_FAST_ZERO_SAMPLING_BIT];
      vr_q <= avs_writedata_i[2:0];
    end
  end

  // A rising with B low means A leads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      enc_dir_q <= 1'b0;
    end else begin
      a_q <= rotor_input_a_i;
      b_q <= rotor_input_b_i;
      if (rotor_input_a_i && !a_q) begin
        enc_dir_q <= ~rotor_input_b_i;
      end else if (rotor_input_b_i && !b_q) begin
        enc_dir_q <= rotor_input_a_i ? 1'b1 : 1'b0;
      end
    end
  end

  // hardware Z only in position/sensorless mode
  assign hardware_zero_cross_select_o = hz_q & ~speed_mode;
  assign simulated_zero_cross_o = sz_q;
  assign simulated_commutation_o = sc_q & mode_q.autoswitched_mode;
  // Z sample source in sensorless mode
  assign z_sample_strobe_o = mode_q.position_sensor_mode ? 1'b0 :
                             (fast_zero_sampling_q ? fast_sample_clock_i : pwm_off_end_i);
  // fast sampling removes the minimum off time
  assign effective_off_time_o = fast_zero_sampling_q ? 4'h0 : minimum_off_time_i;
  assign threshold_level_select_o = vr_q;
  assign external_threshold_pin_sel_o = (vr_q == VR_EXTERNAL);

  // ---------------------------------------------------------------
  // mode, control b, phase state and C event preload
  // ---------------------------------------------------------------
  logic phase_wr;
  logic c_evt;
  assign phase_wr = wr_take & (sel == SEL_PHASE);
  assign c_evt = c_event_i | dac_c_q;
  assign c_event_o = c_evt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= RST_MODE_CTRL;
      control_b_q <= RST_CONTROL_B;
      phase_q <= RST_PHASE_STATE;
    end else if (sw_rst) begin
      mode_q <= RST_MODE_CTRL;
      control_b_q <= RST_CONTROL_B;
      phase_q <= RST_PHASE_STATE;
    end else if (wr_take) begin
      if (sel == SEL_MODE) begin
        mode_q <= {3'h0, avs_writedata_i[4:0]};
      end
      if (sel == SEL_CONTROL_B) begin
        control_b_q <= {1'b0, avs_writedata_i[6:0]};
      end
      if (sel == SEL_PHASE) begin
        phase_q <= avs_writedata_i;
      end
    end
  end

  // a write in direct access is itself a C event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_c_q <= 1'b0;
    end else begin
      dac_c_q <= phase_wr & mode_q.direct_access & ~sw_rst;
    end
  end

  // channel bits at C event, or at once in direct access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_act_q <= RST_PHASE_STATE;
      cb_act_q <= RST_CONTROL_B;
    end else if (sw_rst) begin
      phase_act_q <= RST_PHASE_STATE;
      cb_act_q <= RST_CONTROL_B;
    end else begin
      if (phase_wr && mode_q.direct_access) begin
        phase_act_q <= avs_writedata_i;
      end else if (c_evt) begin
        phase_act_q <= phase_q;
      end
      // preload bits of control b move at C, the rest at once
      cb_act_q <= (control_b_q & ~CB_PRELOAD_MASK) |
                  ((c_evt ? control_b_q : cb_act_q) & CB_PRELOAD_MASK);
    end
  end

  assign channel_on_bits_o = phase_act_q.channel_on;
  assign control_b_active_o = cb_act_q;
  // direct access uses only the low mode bit
  assign pwm_low_side_o = mode_q.direct_access ? cb_act_q[0] : cb_act_q[2];
  assign encoder_mode_o = (phase_act_q.input_sel == IS_ENCODER);
  assign comparator_channel_o = encoder_mode_o ? 3'h0 : (3'h1 << phase_act_q.input_sel);

  // ---------------------------------------------------------------
  // current feedback register, page and d filter register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q <= RST_CURRENT_FEEDBACK[CFR_PAGE_BIT];
      cff_q <= RST_CURRENT_FEEDBACK[5:3];
      cfw_q <= RST_CURRENT_FEEDBACK[2:0];
      dfr_q <= RST_D_EVENT_FILTER;
    end else if (sw_rst) begin
      page_q <= RST_CURRENT_FEEDBACK[CFR_PAGE_BIT];
      cff_q <= RST_CURRENT_FEEDBACK[5:3];
      cfw_q <= RST_CURRENT_FEEDBACK[2:0];
      dfr_q <= RST_D_EVENT_FILTER;
    end else if (wr_take) begin
      if (sel == SEL_CFR) begin
        page_q <= avs_writedata_i[CFR_PAGE_BIT];
        cff_q <= avs_writedata_i[5:3];
        cfw_q <= avs_writedata_i[2:0];
      end
      if (sel == SEL_DFR) begin
        dfr_q <= avs_writedata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // current comparator blanking and filter
  // ---------------------------------------------------------------
  logic [8:0] blank_q;
  logic [1:0] div_q;
  logic [3:0] cur_cnt_q;
  logic cur_valid;

  // blanking window reloads on each PWM turn-on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blank_q <= 9'h000;
    end else if (pwm_turn_on_i) begin
      blank_q <= 9'(int'(cfw_q) * BLANK_STEP_CYC);
    end else if (blank_q != 9'h000) begin
      blank_q <= blank_q - 9'h001;
    end
  end
  assign cur_valid = current_above_i & (blank_q == 9'h000) & ~pwm_turn_on_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 2'h0;
      cur_cnt_q <= 4'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == CUR_DIV_LAST) begin
        if (!cur_valid) begin
          cur_cnt_q <= 4'h0;
        end else if (cur_cnt_q != 4'h8) begin
          cur_cnt_q <= cur_cnt_q + 4'h1;
        end
      end
    end
  end
  assign over_current_o = (cur_cnt_q > {1'b0, cff_q});

  // ---------------------------------------------------------------
  // D event window and filter
  // ---------------------------------------------------------------
  logic [15:0] dwin_q;
  logic [4:0] d_cnt_q;
  logic [4:0] d_need;
  logic d_valid;

  function automatic logic [15:0] dwin_len(input logic [3:0] code);
    if (!code[3]) begin
      dwin_len = 16'((int'(code) + 1) * D_WIN_FINE);
    end else begin
      dwin_len = 16'(D_WIN_BREAK + int'(code[2:0]) * D_WIN_COARSE);
    end
  endfunction

  // window starts at C, sensorless only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dwin_q <= 16'h0000;
    end else if (c_evt && !mode_q.position_sensor_mode) begin
      dwin_q <= dwin_len(dfr_q[3:0]);
    end else if (dwin_q != 16'h0000) begin
      dwin_q <= dwin_q - 16'h0001;
    end
  end

  assign d_valid = d_detect_i & (dwin_q == 16'h0000) & ~(c_evt & ~mode_q.position_sensor_mode);
  assign d_need = mode_q.position_sensor_mode ? 5'h01 : {1'b0, dfr_q[7:4]} + 5'h01;

  // count consecutive samples on the fast clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_cnt_q <= 5'h00;
      d_event_o <= 1'b0;
    end else begin
      d_event_o <= 1'b0;
      if (fast_sample_clock_i) begin
        if (!d_valid) begin
          d_cnt_q <= 5'h00;
        end else if (d_cnt_q != 5'h1f) begin
          d_cnt_q <= d_cnt_q + 5'h01;
          d_event_o <= (d_cnt_q + 5'h01 == d_need);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_flag_overflow: assert property (
    (!speed_mode && motor_timer_overflow_i && !sw_rst) |=> flag_q)
    else $error("overflow flag not set");
  a_flag_tacho: assert property (
    (speed_mode && tacho_error_i && !sw_rst) |=> flag_q)
    else $error("tacho error flag not set");
  a_dir_lead: assert property (
    (rotor_input_a_i && !a_q && !rotor_input_b_i) |=> enc_dir_q)
    else $error("encoder lead not reported");
  a_hz_output: assert property (
    speed_mode |-> !hardware_zero_cross_select_o)
    else $error("hardware zero select leaks in speed mode");
  a_z_fast: assert property (
    (!mode_q.position_sensor_mode && fast_zero_sampling_q) |-> z_sample_strobe_o == fast_sample_clock_i)
    else $error("fast Z sampling source wrong");
  a_off_forced: assert property (
    fast_zero_sampling_q |-> effective_off_time_o == 4'h0)
    else $error("off time not forced");
  a_ext_ref: assert property (
    (wr_take && sel == SEL_CONTROL_C) |=>
      external_threshold_pin_sel_o == ($past(avs_writedata_i[2:0]) == VR_EXTERNAL))
    else $error("external reference select wrong");
  a_preload_hold: assert property (
    (!c_evt && !(phase_wr && mode_q.direct_access) && !sw_rst) |=> $stable(phase_act_q))
    else $error("channel bits moved without C event");
  a_direct_now: assert property (
    (phase_wr && mode_q.direct_access && !sw_rst) |=> (phase_act_q == $past(avs_writedata_i) && c_evt))
    else $error("direct access write not applied");
  a_soft_reset: assert property (
    sw_rst |=> dfr_q == RST_D_EVENT_FILTER && phase_q == RST_PHASE_STATE && !page_q)
    else $error("soft reset incomplete");
  a_blank_mask: assert property (
    (pwm_turn_on_i && cfw_q != 3'h0) |=> !cur_valid [*8])
    else $error("current not blanked after turn-on");
  a_oc_count: assert property (
    (over_current_o && div_q == CUR_DIV_LAST && !cur_valid) |=> !over_current_o)
    else $error("over-current held after low sample");
  a_bus_wait: assert property (
    (req && !ack_q) |-> avs_waitrequest_o ##1 (!req || !avs_waitrequest_o))
    else $error("waitrequest sequence wrong");

  c_direct_write: cover property (phase_wr && mode_q.direct_access);
  c_over_current: cover property ($rose(over_current_o));
  c_d_event: cover property (d_event_o && dfr_q[7:4] != 4'h0);
  c_page_one: cover property (wr_take && sel == SEL_DFR);

endmodule

// ### rotor_encoder_model.sv
`timescale 1ns/1ps
module rotor_encoder_model (
  // clock
  input wire logic clk_i,
  // control
  input wire logic run_i,
  input wire logic fwd_i,
  // quadrature outputs
  output logic rotor_a_o,
  output logic rotor_b_o
);
  logic [1:0] phase_q = 2'h0;
  logic [1:0] div_q = 2'h0;
  // one step every 4 cycles so each edge is seen on its own
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (run_i && div_q == 2'h3) begin
      phase_q <= fwd_i ? phase_q + 2'h1 : phase_q - 2'h1;
    end
  end
  // gray order 00,10,11,01 (a,b): forward means a leads b
  assign rotor_a_o = phase_q[1] ^ phase_q[0];
  assign rotor_b_o = phase_q[1];
endmodule

// ### test_motor_ctrl_phase_filter_regs.sv
`timescale 1ns/1ps
module test_motor_ctrl_phase_filter_regs;
  import motor_regs_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [2:0] avs_address_i = 3'h0;
  logic [7:0] avs_writedata_i = 8'h00;
  logic motor_timer_overflow_i = 1'b0, tacho_error_i = 1'b0, c_event_i = 1'b0, pwm_off_end_i = 1'b0;
  logic fast_sample_clock_i = 1'b0, pwm_turn_on_i = 1'b0, current_above_i = 1'b0, d_detect_i = 1'b0;
  logic [3:0] minimum_off_time_i = 4'h9;
  logic rotor_input_a_i, rotor_input_b_i, avs_waitrequest_o, hardware_zero_cross_select_o;
  logic simulated_zero_cross_o, simulated_commutation_o, z_sample_strobe_o, external_threshold_pin_sel_o;
  logic encoder_mode_o, pwm_low_side_o, c_event_o, over_current_o, d_event_o;
  logic [7:0] avs_readdata_o, control_b_active_o;
  logic [3:0] effective_off_time_o;
  logic [2:0] threshold_level_select_o, comparator_channel_o;
  logic [5:0] channel_on_bits_o;
  logic enc_run = 1'b0, enc_fwd = 1'b1;
  logic [7:0] q;
  int errors = 0, n_checks = 0, d_cnt = 0, c_cnt = 0, n;

  motor_ctrl_phase_filter_regs #(.D_WIN_FINE(5), .D_WIN_COARSE(20), .D_WIN_BREAK(60))
    motor_ctrl_phase_filter_regs_inst (.*);
  rotor_encoder_model rotor_encoder_model_inst (.clk_i(clk_i), .run_i(enc_run), .fwd_i(enc_fwd),
    .rotor_a_o(rotor_input_a_i), .rotor_b_o(rotor_input_b_i));

  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (d_event_o === 1'b1) d_cnt++;
    if (c_event_o === 1'b1) c_cnt++;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    // values read here are those sampled by this rising edge
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      complete_run();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // let the landed write settle before callers look
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    chk(q, exp, what);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic tick();
    @(posedge clk_i);
    fast_sample_clock_i <= 1'b1;
    @(posedge clk_i);
    fast_sample_clock_i <= 1'b0;
  endtask
  task automatic c_pulse();
    @(posedge clk_i);
    c_event_i <= 1'b1;
    @(posedge clk_i);
    c_event_i <= 1'b0;
    wt(1);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    rd(OFF_CONTROL_B, RST_CONTROL_B, "ctrl b");
    rd(OFF_CONTROL_C, RST_CONTROL_C, "ctrl c");
    rd(OFF_PHASE_STATE, RST_PHASE_STATE, "phase");
    rd(OFF_PAGED, RST_MODE_CTRL, "page 0");
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00, "unmapped");
    wr(OFF_CURRENT_FEEDBACK, 8'h80);
    rd(OFF_PAGED, RST_D_EVENT_FILTER, "page 1");
    rd(OFF_CURRENT_FEEDBACK, 8'h80, "cfr");
    wr(OFF_CURRENT_FEEDBACK, 8'h00);
    chk({2'h0, channel_on_bits_o}, 8'h00, "active chan");
  endtask
  task automatic t_flags();
    @(posedge clk_i);
    motor_timer_overflow_i <= 1'b1;
    @(posedge clk_i);
    motor_timer_overflow_i <= 1'b0;
    rd(OFF_CONTROL_C, 8'h80, "overflow");
    wr(OFF_CONTROL_C, 8'h40);
    rd(OFF_CONTROL_C, 8'h40, "clear, hz");
    chk({7'h0, hardware_zero_cross_select_o}, 8'h01, "hz out");
    wr(OFF_PAGED, 8'h01);
    @(posedge clk_i);
    tacho_error_i <= 1'b1;
    enc_run <= 1'b1;
    @(posedge clk_i);
    tacho_error_i <= 1'b0;
    wt(20);
    bus(1'b0, OFF_CONTROL_C, 8'h00);
    chk(q & 8'hc0, 8'hc0, "tacho, a leads");
    chk({7'h0, hardware_zero_cross_select_o}, 8'h00, "hz speed");
    enc_fwd <= 1'b0;
    wr(OFF_CONTROL_C, 8'h00);
    wt(20);
    bus(1'b0, OFF_CONTROL_C, 8'h00);
    chk(q & 8'hc0, 8'h00, "cleared, a lags");
    enc_run <= 1'b0;
    wr(OFF_PAGED, 8'h00);
  endtask
  task automatic t_ctrl_outputs();
    wr(OFF_PAGED, 8'h04);
    wr(OFF_CONTROL_C, 8'h3f);
    rd(OFF_CONTROL_C, 8'h3f, "ctrl c rw");
    chk({2'h0, simulated_zero_cross_o, simulated_commutation_o, external_threshold_pin_sel_o,
      threshold_level_select_o}, 8'h3f, "sim, ext");
    chk({4'h0, effective_off_time_o}, 8'h00, "off forced");
    @(posedge clk_i);
    fast_sample_clock_i <= 1'b1;
    @(negedge clk_i);
    chk({7'h0, z_sample_strobe_o}, 8'h01, "fast z");
    @(posedge clk_i);
    fast_sample_clock_i <= 1'b0;
    pwm_off_end_i <= 1'b1;
    @(negedge clk_i);
    chk({7'h0, z_sample_strobe_o}, 8'h00, "no off-end z");
    wr(OFF_CONTROL_C, 8'h06);
    chk({4'h0, effective_off_time_o}, 8'h09, "off kept");
    chk({2'h0, simulated_zero_cross_o, simulated_commutation_o, external_threshold_pin_sel_o,
      threshold_level_select_o}, 8'h06, "internal");
    chk({7'h0, z_sample_strobe_o}, 8'h01, "off-end z");
    @(posedge clk_i);
    pwm_off_end_i <= 1'b0;
    wr(OFF_PAGED, 8'h00);
    wr(OFF_CONTROL_C, 8'h10);
    chk({7'h0, simulated_commutation_o}, 8'h00, "not autosw");
    wr(OFF_CONTROL_C, 8'h00);
  endtask
  task automatic t_phase();
    wr(OFF_PHASE_STATE, 8'h85);
    chk({2'h0, channel_on_bits_o}, 8'h00, "preload held");
    c_pulse();
    chk({comparator_channel_o, channel_on_bits_o[4:0]}, 8'h85, "c applies");
    wr(OFF_PHASE_STATE, 8'hc0);
    c_pulse();
    chk({encoder_mode_o, comparator_channel_o}, 8'h08, "encoder");
    wr(OFF_PHASE_STATE, 8'h40);
    c_pulse();
    chk({encoder_mode_o, comparator_channel_o}, 8'h02, "input b");
    wr(OFF_PAGED, 8'h10);
    wr(OFF_CONTROL_B, 8'h06);
    wt(2);
    chk({7'h0, pwm_low_side_o}, 8'h00, "high side");
    chk(control_b_active_o, 8'h02, "b preload held");
    wr(OFF_CONTROL_B, 8'h01);
    wt(2);
    chk({7'h0, pwm_low_side_o}, 8'h01, "low side");
    n = c_cnt;
    wr(OFF_PHASE_STATE, 8'h2a);
    wt(3);
    chk({2'h0, channel_on_bits_o}, 8'h2a, "direct");
    chk(8'(c_cnt - n), 8'h01, "direct c");
    wr(OFF_PAGED, 8'h00);
    wr(OFF_CONTROL_B, 8'h00);
  endtask
  task automatic t_current();
    wr(OFF_CURRENT_FEEDBACK, 8'h10);
    @(posedge clk_i);
    current_above_i <= 1'b1;
    wt(6);
    chk({7'h0, over_current_o}, 8'h00, "2 samples");
    wt(16);
    chk({7'h0, over_current_o}, 8'h01, "3 samples");
    @(posedge clk_i);
    current_above_i <= 1'b0;
    wt(12);
    chk({7'h0, over_current_o}, 8'h00, "dropped");
    wr(OFF_CURRENT_FEEDBACK, 8'h01);
    @(posedge clk_i);
    pwm_turn_on_i <= 1'b1;
    current_above_i <= 1'b1;
    @(posedge clk_i);
    pwm_turn_on_i <= 1'b0;
    wt(30);
    chk({7'h0, over_current_o}, 8'h00, "blanked");
    wt(40);
    chk({7'h0, over_current_o}, 8'h01, "after blank");
    @(posedge clk_i);
    current_above_i <= 1'b0;
  endtask
  task automatic t_d_filter();
    wr(OFF_CURRENT_FEEDBACK, 8'h80);
    wr(OFF_PAGED, 8'h20);
    rd(OFF_PAGED, 8'h20, "dfr");
    // older C events left a long D window running
    c_pulse();
    @(posedge clk_i);
    d_detect_i <= 1'b1;
    wt(10);
    n = d_cnt;
    tick();
    tick();
    wt(3);
    chk(8'(d_cnt - n), 8'h00, "2 of 3");
    tick();
    wt(3);
    chk(8'(d_cnt - n), 8'h01, "3 of 3");
    wr(OFF_PAGED, 8'h00);
    n = d_cnt;
    c_pulse();
    tick();
    wt(1);
    chk(8'(d_cnt - n), 8'h00, "in window");
    wt(10);
    tick();
    wt(3);
    chk(8'(d_cnt - n), 8'h01, "after window");
    @(posedge clk_i);
    d_detect_i <= 1'b0;
    wr(OFF_CURRENT_FEEDBACK, 8'h00);
  endtask
  task automatic t_soft_reset();
    wr(OFF_CONTROL_C, 8'h07);
    wr(OFF_CURRENT_FEEDBACK, 8'h80);
    wr(OFF_PAGED, 8'h55);
    wr(OFF_CURRENT_FEEDBACK, 8'h40);
    t_reset_values();
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_flags();
    t_ctrl_outputs();
    t_phase();
    t_current();
    t_d_filter();
    t_soft_reset();
    complete_run();
  end
endmodule
